// ==== common/stnp_pkg.sv ====
// Contract
// - Serial rate 110 bps to 230.4 kbps, default 115.2k.
// - Five data bits force one and half stops.
// - Sixteen byte queues each way, disable bit.
// - Idle link timeout closes connection, zero disables.
// - One to four concurrent hosts, default one.
// - Several hosts use stored serial settings only.
// - Network bytes reach serial line in order.
// - Skip option passes stalled hosts, else wait.
// - Several hosts discard control unless allowed.
// - Latest accepted control command wins.
// - Packing length flushes buffer, zero disables.
// - Delimiter pair received flushes whole buffer.
// - First delimiter alone flushes without second.
// - Full buffer flushes regardless of delimiters.
// - Plus one or two delays flush.
// - Strip option drops delimiter, sends remainder.
// - Default action sends buffer including delimiter.
// - Force interval groups bytes, zero disables.
// - Force scheme sends on full or expiry.
// - Separate 1 KB serial to network buffer.
package stnp_pkg;

	//**********************************************************
	// Timing and sizes.
	//**********************************************************
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_HZ = 25000000;
	localparam int BAUD_DEF_BPS = 115200;
	localparam logic [17:0] DIV_DEF = 18'(CLK_HZ / BAUD_DEF_BPS);
	localparam int MS_TIME_NS = 1000000;
	localparam int CYC_PER_MS = MS_TIME_NS / CLK_PERIOD_NS;
	localparam logic [15:0] MIN_TIME_MS = 16'hEA60;
	localparam int BUF_BYTES = 1024;
	localparam logic [4:0] FIFO_DEPTH = 5'h10;

	//**********************************************************
	// Register indices, one word each.
	//**********************************************************
	localparam logic [2:0] REG_SER = 3'h0;
	localparam logic [2:0] REG_NET = 3'h1;
	localparam logic [2:0] REG_PACK = 3'h2;
	localparam logic [2:0] REG_DELIM = 3'h3;
	localparam logic [2:0] REG_FORCE = 3'h4;
	localparam logic [2:0] REG_STAT = 3'h5;
	localparam int STAT_FLG_POS = 16;

	//**********************************************************
	// Field layouts, first field is the most significant.
	//**********************************************************
	typedef struct packed {
		logic        fifo_en;
		logic [2:0]  parity;
		logic        stop2;
		logic [1:0]  dbits;
		logic [17:0] div;
	} stnp_ser_type;

	typedef struct packed {
		logic       allow_ctl;
		logic       skip;
		logic [2:0] max_hosts;
		logic [6:0] idle_min;
	} stnp_net_type;

	typedef struct packed {
		logic [1:0]  post;
		logic [10:0] plen;
	} stnp_pack_type;

	typedef struct packed {
		logic       d2_en;
		logic       d1_en;
		logic [7:0] d2;
		logic [7:0] d1;
	} stnp_delim_type;

	typedef enum logic [1:0] {
		ST_FILL = 2'b01,
		ST_SEND = 2'b10
	} stnp_st_type;

	localparam logic [1:0] POST_NONE = 2'h0;
	localparam logic [1:0] POST_STRIP = 2'h3;
	localparam logic [2:0] PAR_NONE = 3'h0;
	localparam logic [2:0] PAR_EVEN = 3'h1;
	localparam logic [2:0] PAR_ODD = 3'h2;
	localparam logic [2:0] PAR_SPACE = 3'h3;

	//**********************************************************
	// Values after reset.
	//**********************************************************
	localparam stnp_ser_type SER_RST = '{fifo_en: 1'b1,
		parity: PAR_NONE, stop2: 1'b0, dbits: 2'h3, div: DIV_DEF};
	localparam stnp_net_type NET_RST = '{allow_ctl: 1'b0,
		skip: 1'b0, max_hosts: 3'h1, idle_min: 7'h07};

endpackage

// ==== logic/stnp_top.sv ====
`timescale 1ns/1ps
module stnp_top import stnp_pkg::*; #(
	parameter int CYC_MS = CYC_PER_MS
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [2:0]   avs_address_i,
	input  wire logic         avs_read_i,
	input  wire logic         avs_write_i,
	input  wire logic [31:0]  avs_writedata_i,
	output logic [31:0]       avs_readdata_o,
	output logic              avs_waitrequest_o,
	input  wire logic         rxd_i,
	output logic              txd_o,
	input  wire logic [7:0]   net_data_i,
	input  wire logic         net_valid_i,
	output logic              net_ready_o,
	input  wire logic         cmd_valid_i,
	input  wire stnp_ser_type cmd_ser_i,
	input  wire logic [3:0]   host_req_i,
	output logic [3:0]        host_conn_o,
	output logic              conn_close_o,
	output logic [7:0]        frm_data_o,
	output logic              frm_valid_o,
	output logic              frm_last_o,
	input  wire logic [3:0]   frm_ready_i
);

	//**********************************************************
	// Helpers.
	//**********************************************************
	// Counts the connected hosts.
	function automatic logic [2:0] popcnt(input logic [3:0] v);
		popcnt = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
	endfunction

	// Gives the parity bit for the chosen parity mode.
	function automatic logic par_bit(input logic [2:0] m,
		input logic [7:0] d);
		if (m == PAR_EVEN) begin
			par_bit = ^d;
		end else if (m == PAR_ODD) begin
			par_bit = ~^d;
		end else begin
			par_bit = (m != PAR_SPACE);
		end
	endfunction

	//**********************************************************
	// State.
	//**********************************************************
	typedef struct packed {
		stnp_ser_type   ser;
		stnp_net_type   net;
		stnp_pack_type  pk;
		stnp_delim_type dl;
		logic [15:0]    frc;
		logic           wr;
		logic [31:0]    rdat;
		logic [3:0]     flg;
		logic [3:0]     conn;
		logic [3:0]     kill;
		logic           close;
		logic [14:0]    tick;
		logic [15:0]    ms_f;
		logic [15:0]    ms_i;
		logic [6:0]     min_i;
		stnp_st_type    st;
		logic [10:0]    cnt;
		logic [10:0]    flen;
		logic [10:0]    rd;
		logic           prev_d1;
		logic [1:0]     post;
		logic           fv;
		logic           fl;
		logic [7:0]     fd;
		logic [3:0]     rwp;
		logic [3:0]     rrp;
		logic [4:0]     rcn;
		logic [3:0]     twp;
		logic [3:0]     trp;
		logic [4:0]     tcn;
		logic           nrdy;
		logic           rbusy;
		logic [17:0]    rdiv;
		logic [3:0]     ridx;
		logic [11:0]    rsh;
		logic           tbusy;
		logic [17:0]    tdiv;
		logic [4:0]     thalf;
		logic [11:0]    tfr;
		logic           txd;
	} stnp_state_type;

	stnp_state_type s_r;                 // Registered state.
	stnp_state_type s_nxt;               // Next state.
	logic [7:0]     rxm [16];            // Receive queue.
	logic [7:0]     txm [16];            // Transmit queue.
	logic [7:0]     bm [BUF_BYTES];      // Packing buffer.
	logic           rx_we;               // Receive queue write.
	logic [7:0]     rx_wd;               // Receive queue data.
	logic           tx_we;               // Transmit queue write.
	logic           bm_we;               // Packing buffer write.
	logic [7:0]     b;                   // Byte taken from the queue.
	logic [7:0]     d;                   // Assembled character.
	logic [3:0]     nb;                  // Data bits per character.
	logic           pe;                  // Parity bit present.
	logic [4:0]     cap;                 // Queue capacity.
	logic [17:0]    half;                // Half bit time.
	logic [4:0]     tot;                 // Half bits per character.
	logic [3:0]     last;                // Index of the stop bit.
	logic [10:0]    c_n;                 // Buffer fill after a byte.
	logic [2:0]     hc;                  // Host count.
	logic [2:0]     maxh;                // Effective host limit.
	logic           ms;                  // Millisecond tick.
	logic           acc;                 // Frame byte taken.
	logic           pop;                 // Queue byte taken.
	logic           store;               // Byte goes to the buffer.
	logic           flush;               // Frame starts.
	logic           dact;                // Delimiter scheme on.
	logic           hit;                 // Delimiter completed.
	logic           tpush;               // Network byte taken.
	logic           tpop;                // Transmit byte taken.
	logic [31:0]    rword;               // Read data selected.

	//**********************************************************
	// Next state.
	//**********************************************************
	// Computes the whole next state in one place.
	always_comb begin
		s_nxt = s_r;
		rx_we = 1'b0;
		rx_wd = 8'h00;
		bm_we = 1'b0;
		b = rxm[s_r.rrp];
		d = 8'h00;
		nb = 4'(s_r.ser.dbits) + 4'h5;
		pe = (s_r.ser.parity != PAR_NONE);
		cap = s_r.ser.fifo_en ? FIFO_DEPTH : 5'h01;
		half = (s_r.ser.div > 18'h00001) ? (s_r.ser.div >> 1) :
			18'h00001;
		last = nb + 4'(pe) + 4'h1;
		// Five bit characters always end with three half bits.
		tot = 5'({nb + 4'(pe) + 4'h1, 1'b0}) +
			((s_r.ser.dbits == 2'h0) ? 5'h03 :
			(s_r.ser.stop2 ? 5'h04 : 5'h02));
		ms = (s_r.tick == 15'(CYC_MS - 1));
		s_nxt.tick = ms ? 15'h0000 : s_r.tick + 15'h0001;
		s_nxt.close = 1'b0;
		rword = 32'h00000000;

		// Register bus, one wait state per access.
		if (avs_address_i == REG_SER) begin
			rword = 32'(s_r.ser);
		end else if (avs_address_i == REG_NET) begin
			rword = 32'(s_r.net);
		end else if (avs_address_i == REG_PACK) begin
			rword = 32'(s_r.pk);
		end else if (avs_address_i == REG_DELIM) begin
			rword = 32'(s_r.dl);
		end else if (avs_address_i == REG_FORCE) begin
			rword = 32'(s_r.frc);
		end else if (avs_address_i == REG_STAT) begin
			rword = {12'h000, s_r.flg, s_r.st == ST_SEND,
				s_r.conn, s_r.cnt};
		end
		if ((avs_read_i || avs_write_i) && s_r.wr) begin
			s_nxt.wr = 1'b0;
			s_nxt.rdat = avs_read_i ? rword : s_r.rdat; // Writes keep it.
		end else begin
			s_nxt.wr = 1'b1;
		end
		if (avs_write_i && !s_r.wr) begin
			if (avs_address_i == REG_SER) begin
				s_nxt.ser = stnp_ser_type'(
					avs_writedata_i[$bits(stnp_ser_type)-1:0]);
			end else if (avs_address_i == REG_NET) begin
				s_nxt.net = stnp_net_type'(
					avs_writedata_i[$bits(stnp_net_type)-1:0]);
			end else if (avs_address_i == REG_PACK) begin
				s_nxt.pk = stnp_pack_type'(
					avs_writedata_i[$bits(stnp_pack_type)-1:0]);
			end else if (avs_address_i == REG_DELIM) begin
				s_nxt.dl = stnp_delim_type'(
					avs_writedata_i[$bits(stnp_delim_type)-1:0]);
			end else if (avs_address_i == REG_FORCE) begin
				s_nxt.frc = avs_writedata_i[15:0];
			end else if (avs_address_i == REG_STAT) begin
				s_nxt.flg = s_r.flg &
					~avs_writedata_i[STAT_FLG_POS+3:STAT_FLG_POS];
			end
		end

		// Host commands, taken after the bus so they win a tie.
		hc = popcnt(s_r.conn);
		if (cmd_valid_i) begin
			if (hc <= 3'h1 || s_r.net.allow_ctl) begin
				s_nxt.ser = cmd_ser_i;
			end else begin
				s_nxt.flg[3] = 1'b1;
			end
		end

		// Host connections, limited to the configured count.
		maxh = (s_r.net.max_hosts == 3'h0) ? 3'h1 :
			((s_r.net.max_hosts > 3'h4) ? 3'h4 : s_r.net.max_hosts);
		s_nxt.conn = s_r.conn & host_req_i;
		s_nxt.kill = s_r.kill & host_req_i;
		hc = popcnt(s_nxt.conn);
		for (int i = 0; i < 4; i++) begin
			if (!s_nxt.conn[i] && host_req_i[i] && !s_r.kill[i] &&
				hc < maxh) begin
				s_nxt.conn[i] = 1'b1;
				hc = hc + 3'h1;
			end
		end

		// Frame bytes pass when the hosts in play take them.
		if (s_r.net.skip && popcnt(s_r.conn) > 3'h1) begin
			acc = s_r.fv && |(frm_ready_i & s_r.conn);
		end else begin
			acc = s_r.fv && &(frm_ready_i | ~s_r.conn);
		end
		tpush = net_valid_i && s_r.nrdy;

		// Idle link timer in whole minutes.
		if (cmd_valid_i || acc || tpush || s_r.conn == 4'h0) begin
			s_nxt.ms_i = 16'h0000;
			s_nxt.min_i = 7'h00;
		end else if (ms) begin
			if (s_r.ms_i == MIN_TIME_MS - 16'h0001) begin
				s_nxt.ms_i = 16'h0000;
				s_nxt.min_i = s_r.min_i + 7'h01;
			end else begin
				s_nxt.ms_i = s_r.ms_i + 16'h0001;
			end
		end
		if (s_r.net.idle_min != 7'h00 &&
			s_r.min_i >= s_r.net.idle_min) begin
			s_nxt.kill = s_nxt.kill | s_r.conn;
			s_nxt.conn = 4'h0;
			s_nxt.close = 1'b1;
			s_nxt.ms_i = 16'h0000;
			s_nxt.min_i = 7'h00;
		end

		// Serial receiver, sampled at the middle of each bit.
		if (!s_r.rbusy) begin
			if (!rxd_i) begin
				s_nxt.rbusy = 1'b1;
				s_nxt.rdiv = 18'h00000;
				s_nxt.ridx = 4'h0;
			end
		end else if (s_r.rdiv ==
			((s_r.ridx == 4'h0) ? half : s_r.ser.div) - 18'h00001) begin
			s_nxt.rdiv = 18'h00000;
			s_nxt.rsh[s_r.ridx] = rxd_i;
			s_nxt.ridx = s_r.ridx + 4'h1;
			if (s_r.ridx == 4'h0 && rxd_i) begin
				s_nxt.rbusy = 1'b0;
			end else if (s_r.ridx == last) begin
				s_nxt.rbusy = 1'b0;
				for (int i = 0; i < 8; i++) begin
					if (4'(i) < nb) begin
						d[i] = s_r.rsh[i+1];
					end
				end
				if (pe && s_r.rsh[nb+4'h1] !=
					par_bit(s_r.ser.parity, d)) begin
					s_nxt.flg[0] = 1'b1;
				end
				if (!rxd_i) begin
					s_nxt.flg[1] = 1'b1;
				end
				if (s_r.rcn < cap) begin
					rx_we = 1'b1;
					rx_wd = d;
				end else begin
					s_nxt.flg[2] = 1'b1;
				end
			end
		end else begin
			s_nxt.rdiv = s_r.rdiv + 18'h00001;
		end

		// Packing of queued bytes into the buffer.
		pop = (s_r.st == ST_FILL) && (s_r.rcn != 5'h00);
		store = 1'b0;
		flush = 1'b0;
		hit = 1'b0;
		c_n = s_r.cnt;
		dact = (s_r.frc == 16'h0000) && s_r.dl.d1_en;
		if (pop) begin
			s_nxt.rrp = s_r.rrp + 4'h1;
			s_nxt.ms_f = 16'h0000;
			store = 1'b1;
			if (s_r.post != 2'h0) begin
				s_nxt.post = s_r.post - 2'h1;
				flush = (s_r.post == 2'h1);
			end else if (dact) begin
				if (!s_r.dl.d2_en) begin
					hit = (b == s_r.dl.d1);
				end else begin
					hit = s_r.prev_d1 && (b == s_r.dl.d2);
					s_nxt.prev_d1 = (b == s_r.dl.d1);
				end
				if (hit) begin
					s_nxt.prev_d1 = 1'b0;
					if (s_r.pk.post == POST_STRIP) begin
						store = 1'b0;
						if (s_r.dl.d2_en && c_n != 11'h000) begin
							c_n = c_n - 11'h001;
						end
						flush = 1'b1;
					end else if (s_r.pk.post == POST_NONE) begin
						flush = 1'b1;
					end else begin
						s_nxt.post = s_r.pk.post;
					end
				end
			end
			if (store) begin
				bm_we = 1'b1;
				c_n = c_n + 11'h001;
			end
			if (s_r.pk.plen != 11'h000 && s_r.frc == 16'h0000 &&
				c_n == s_r.pk.plen) begin
				flush = 1'b1;
			end
			if (c_n == 11'(BUF_BYTES)) begin
				flush = 1'b1;
			end
		end else if (s_r.st == ST_FILL && s_r.frc != 16'h0000 &&
			s_r.cnt != 11'h000) begin
			if (s_r.ms_f >= s_r.frc) begin
				flush = 1'b1;
			end else if (ms) begin
				s_nxt.ms_f = s_r.ms_f + 16'h0001;
			end
		end
		s_nxt.cnt = c_n;
		if (flush && c_n != 11'h000) begin
			s_nxt.st = ST_SEND;
			s_nxt.flen = c_n;
			s_nxt.rd = 11'h000;
			s_nxt.post = 2'h0;
			s_nxt.prev_d1 = 1'b0;
			s_nxt.ms_f = 16'h0000;
		end

		// Frame output, one byte per accepted cycle.
		if (s_r.st == ST_SEND && (!s_r.fv || acc)) begin
			if (s_r.rd != s_r.flen) begin
				s_nxt.fd = bm[s_r.rd[9:0]];
				s_nxt.fv = 1'b1;
				s_nxt.fl = (s_r.rd == s_r.flen - 11'h001);
				s_nxt.rd = s_r.rd + 11'h001;
			end else begin
				s_nxt.fv = 1'b0;
				s_nxt.fl = 1'b0;
				s_nxt.st = ST_FILL;
				s_nxt.cnt = 11'h000;
			end
		end

		// Receive queue pointers.
		if (rx_we) begin
			s_nxt.rwp = s_r.rwp + 4'h1;
		end
		s_nxt.rcn = s_r.rcn + 5'(rx_we) - 5'(pop);

		// Serial transmitter in half bit steps.
		tpop = !s_r.tbusy && (s_r.tcn != 5'h00);
		if (tpop) begin
			d = txm[s_r.trp];
			s_nxt.tfr = 12'hFFE;
			for (int i = 0; i < 8; i++) begin
				if (4'(i) < nb) begin
					s_nxt.tfr[i+1] = d[i];
				end
			end
			if (pe) begin
				s_nxt.tfr[nb+4'h1] = par_bit(s_r.ser.parity,
					s_nxt.tfr[8:1] & ~(8'hFF << nb));
			end
			s_nxt.tbusy = 1'b1;
			s_nxt.thalf = 5'h00;
			s_nxt.tdiv = 18'h00000;
			s_nxt.trp = s_r.trp + 4'h1;
		end else if (s_r.tbusy) begin
			if (s_r.tdiv == half - 18'h00001) begin
				s_nxt.tdiv = 18'h00000;
				if (s_r.thalf == tot - 5'h01) begin
					s_nxt.tbusy = 1'b0;
				end else begin
					s_nxt.thalf = s_r.thalf + 5'h01;
				end
			end else begin
				s_nxt.tdiv = s_r.tdiv + 18'h00001;
			end
		end
		s_nxt.txd = s_nxt.tbusy ? s_nxt.tfr[s_nxt.thalf[4:1]] : 1'b1;

		// Transmit queue fed from the network in arrival order.
		tx_we = tpush;
		if (tpush) begin
			s_nxt.twp = s_r.twp + 4'h1;
		end
		s_nxt.tcn = s_r.tcn + 5'(tpush) - 5'(tpop);
		s_nxt.nrdy = (s_nxt.tcn < cap);
	end

	//**********************************************************
	// Registers.
	//**********************************************************
	// Holds the state under a synchronous reset.
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
			s_r.ser <= SER_RST;
			s_r.net <= NET_RST;
			s_r.wr <= 1'b1;
			s_r.st <= ST_FILL;
			s_r.nrdy <= 1'b1;
			s_r.txd <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Writes the queues and the packing buffer.
	always_ff @(posedge clk_i) begin
		if (rx_we) begin
			rxm[s_r.rwp] <= rx_wd;
		end
		if (tx_we) begin
			txm[s_r.twp] <= net_data_i;
		end
		if (bm_we) begin
			bm[s_r.cnt[9:0]] <= b;
		end
	end

	//**********************************************************
	// Outputs.
	//**********************************************************
	assign avs_readdata_o = s_r.rdat;
	assign avs_waitrequest_o = s_r.wr;
	assign txd_o = s_r.txd;
	assign net_ready_o = s_r.nrdy;
	assign host_conn_o = s_r.conn;
	assign conn_close_o = s_r.close;
	assign frm_data_o = s_r.fd;
	assign frm_valid_o = s_r.fv;
	assign frm_last_o = s_r.fl;

endmodule

// ==== sim/stnp_asserts.sv ====
`timescale 1ns/1ps
// Watches the register bus, the host links and the frame output.
module stnp_asserts import stnp_pkg::*; #(
	parameter int CYC_MS = CYC_PER_MS
) (
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        txd_o,
	input wire logic [3:0]  host_req_i,
	input wire logic [3:0]  host_conn_o,
	input wire logic        conn_close_o,
	input wire logic [7:0]  frm_data_o,
	input wire logic        frm_valid_o,
	input wire logic        frm_last_o,
	input wire logic [3:0]  frm_ready_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic acc; // A frame byte that every connected host has taken.
	assign acc = frm_valid_o && ((frm_ready_i & host_conn_o) == host_conn_o);
	// A taken request, then a single answer cycle.
	sequence s_take;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_ans;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	property p_answer;
		s_take |=> s_ans;
	endproperty
	property p_idle_wait;
		!(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o;
	endproperty
	property p_rdata;
		$changed(avs_readdata_o) |-> $past(avs_read_i && avs_waitrequest_o);
	endproperty
	property p_host_new;
		1'h1 |-> (host_conn_o & ~$past(host_conn_o) & ~$past(host_req_i)) == 4'h0;
	endproperty
	property p_frm_hold;
		frm_valid_o && host_conn_o != 4'h0 &&
			(frm_ready_i & host_conn_o) == 4'h0 |=> frm_valid_o &&
			$stable(frm_data_o) && $stable(frm_last_o);
	endproperty
	property p_frm_end;
		acc && frm_last_o |=> !frm_valid_o;
	endproperty
	property p_close_pulse;
		conn_close_o |=> !conn_close_o;
	endproperty
	property p_close_drop;
		conn_close_o |-> ##[0:1] host_conn_o == 4'h0;
	endproperty
	// The bench keeps the bit time at eight cycles or more.
	property p_start;
		$fell(txd_o) |-> !txd_o [*8];
	endproperty
	a_answer: assert property (p_answer)
		else $error("bus request not answered in one cycle");
	a_idle_wait: assert property (p_idle_wait)
		else $error("bus answer without request");
	a_rdata: assert property (p_rdata)
		else $error("read data changed without a read");
	a_host_new: assert property (p_host_new)
		else $error("host connected without request");
	a_frm_hold: assert property (p_frm_hold)
		else $error("frame byte not held while hosts stall");
	a_frm_end: assert property (p_frm_end)
		else $error("frame continues after last byte");
	a_close_pulse: assert property (p_close_pulse)
		else $error("close pulse longer than one cycle");
	a_close_drop: assert property (p_close_drop)
		else $error("hosts kept after idle close");
	a_start: assert property (p_start)
		else $error("start bit too short");
endmodule
bind stnp_top stnp_asserts #(.CYC_MS(CYC_MS)) chk_u (.clk_i, .rst_b_i,
	.avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
	.txd_o, .host_req_i, .host_conn_o, .conn_close_o, .frm_data_o,
	.frm_valid_o, .frm_last_o, .frm_ready_i);

// ==== sim/stnp_serdev.sv ====
`timescale 1ns/1ps
// Serial device: sends 8N1 characters and collects what it hears.
module stnp_serdev #(
	parameter int DIV = 16
) (
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	logic [7:0] got_q[$]; // Characters decoded from the device line.
	initial rxd_o = 1'h1;
	// Start bit, data LSB first, one stop bit, each DIV cycles.
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			rxd_o <= f[i];
			repeat (DIV - 1) @(posedge clk_i);
		end
	endtask
	// Samples mid-bit on the falling edge, away from launch edges.
	initial begin
		logic [7:0] b;
		forever begin
			@(negedge txd_i);
			repeat (DIV / 2) @(negedge clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(negedge clk_i);
				b[i] = txd_i;
			end
			repeat (DIV) @(negedge clk_i);
			got_q.push_back(b);
		end
	end
endmodule

// ==== sim/stnp_top_bench.sv ====
`timescale 1ns/1ps
module stnp_top_bench import stnp_pkg::*;;
	logic        clk_i = 1'h0;
	logic        rst_b_i = 1'h0;
	logic [2:0]  avs_address_i = 3'h0;
	logic        avs_read_i = 1'h0;
	logic        avs_write_i = 1'h0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        rxd_i;
	logic        txd_o;
	logic [7:0]  net_data_i = 8'h0;
	logic        net_valid_i = 1'h0;
	logic        net_ready_o;
	logic [3:0]  host_req_i = 4'h0;
	logic [3:0]  host_conn_o;
	logic        conn_close_o;
	logic [7:0]  frm_data_o;
	logic        frm_valid_o;
	logic        frm_last_o;
	logic [3:0]  frm_ready_i = 4'hF;
	logic        cmd_valid_i = 1'h0;
	stnp_ser_type cmd_ser_i = '0;       // Settings carried by a command.
	int          n_close = 0;          // Idle close pulses seen.
	int          miscompares = 0;
	int          n_compared = 0;
	logic [8:0]  frm_q[$]; // Accepted frame bytes with their last flag.
	logic [31:0] q;        // Data of the latest bus read.
	// One cycle per millisecond keeps a minute at 60000 cycles.
	stnp_top #(.CYC_MS(1)) dut_u (.clk_i, .rst_b_i, .avs_address_i,
		.avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o, .rxd_i, .txd_o, .net_data_i, .net_valid_i,
		.net_ready_o, .cmd_valid_i, .cmd_ser_i, .host_req_i,
		.host_conn_o, .conn_close_o, .frm_data_o, .frm_valid_o,
		.frm_last_o, .frm_ready_i);
	stnp_serdev #(.DIV(16)) ser_u (.clk_i, .txd_i(txd_o), .rxd_o(rxd_i));
	always #20 clk_i = ~clk_i;
	// Records each byte at the edge where the connected hosts take it.
	always @(posedge clk_i) begin
		if (rst_b_i && frm_valid_o === 1'h1 &&
			(frm_ready_i & host_conn_o) === host_conn_o) begin
			frm_q.push_back({frm_last_o, frm_data_o});
		end
		if (rst_b_i && conn_close_o === 1'h1) begin
			n_close++;
		end
	end
	//**********************************************************
	// Tasks.
	//**********************************************************
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e,
		input string m);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic tmo(input int n, input string m);
		if (n >= 30000) begin
			miscompares++;
			$display("unexpected at %0t: no answer on %s", $time, m);
			stop_test();
		end
	endtask
	// Avalon access; the request stands until waitrequest is seen low.
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'h0 && n < 30000);
		tmo(n, "bus");
		q = avs_readdata_o;
		avs_read_i <= 1'h0;
		avs_write_i <= 1'h0;
		@(posedge clk_i);
	endtask
	// Host control command, valid for one cycle.
	task automatic cmd(input logic [24:0] v);
		cmd_ser_i <= stnp_ser_type'(v);
		cmd_valid_i <= 1'h1;
		@(posedge clk_i);
		cmd_valid_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic net_send(input logic [7:0] b);
		int n;
		n = 0;
		net_data_i <= b;
		net_valid_i <= 1'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (net_ready_o !== 1'h1 && n < 30000);
		tmo(n, "net");
		net_valid_i <= 1'h0;
		@(posedge clk_i);
	endtask
	// Sends characters from the device, then checks one whole frame.
	task automatic frame(input logic [7:0] s[$], input logic [7:0] e[$],
		input string m);
		int n;
		n = 0;
		foreach (s[i]) ser_u.send(s[i]);
		while (frm_q.size() < e.size() && n < 30000) begin
			@(posedge clk_i);
			n++;
		end
		tmo(n, m);
		repeat (40) @(posedge clk_i);
		cmp(32'(frm_q.size()), 32'(e.size()), m);
		foreach (e[i]) cmp(32'(frm_q[i]), {23'h0, i == e.size() - 1, e[i]}, m);
		frm_q.delete();
		$display("test %s done", m);
	endtask
	//**********************************************************
	// Main sequence.
	//**********************************************************
	initial begin
		int n;
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'h1;
		@(posedge clk_i);
		bus(1'h0, REG_SER, 32'h0);
		cmp(q, 32'h010C00D9, "serial reset");
		bus(1'h0, REG_NET, 32'h0);
		cmp(q, 32'h00000087, "network reset");
		bus(1'h1, 3'h6, 32'hFFFFFFFF);
		bus(1'h0, 3'h6, 32'h0);
		cmp(q, 32'h0, "unmapped");
		bus(1'h1, REG_SER, 32'h010C0010);
		bus(1'h0, REG_SER, 32'h0);
		cmp(q, 32'h010C0010, "serial write");
		$display("test registers done");
		host_req_i <= 4'h3;
		repeat (8) @(posedge clk_i);
		cmp(32'($countones(host_conn_o)), 32'h1, "one host");
		bus(1'h1, REG_DELIM, 32'h0001000D);
		frame({8'h41, 8'h42, 8'h0D}, {8'h41, 8'h42, 8'h0D}, "plain");
		bus(1'h1, REG_PACK, 32'h00001800);
		frame({8'h43, 8'h0D}, {8'h43}, "strip");
		bus(1'h1, REG_PACK, 32'h00001000);
		frm_ready_i <= 4'h0;
		ser_u.send(8'h44);
		ser_u.send(8'h0D);
		ser_u.send(8'h45);
		repeat (40) @(posedge clk_i);
		cmp(32'(frm_q.size()), 32'h0, "early flush");
		frm_ready_i <= 4'hF;
		frame({8'h46}, {8'h44, 8'h0D, 8'h45, 8'h46}, "plus two");
		bus(1'h1, REG_PACK, 32'h0);
		bus(1'h1, REG_DELIM, 32'h00030A0D);
		frame({8'h0D, 8'h47, 8'h0D, 8'h0A}, {8'h0D, 8'h47, 8'h0D, 8'h0A},
			"pair");
		bus(1'h1, REG_DELIM, 32'h0);
		bus(1'h1, REG_PACK, 32'h00000003);
		frame({8'h48, 8'h49, 8'h4A}, {8'h48, 8'h49, 8'h4A}, "length");
		bus(1'h1, REG_FORCE, 32'h00000100);
		frame({8'h4B, 8'h4C}, {8'h4B, 8'h4C}, "force");
		net_send(8'h11);
		net_send(8'h22);
		net_send(8'h33);
		n = 0;
		while (ser_u.got_q.size() < 3 && n < 30000) begin
			@(posedge clk_i);
			n++;
		end
		tmo(n, "serial out");
		cmp(32'(ser_u.got_q[0]), 32'h11, "order");
		cmp(32'(ser_u.got_q[1]), 32'h22, "order");
		cmp(32'(ser_u.got_q[2]), 32'h33, "order");
		$display("test network order done");
		cmd(25'h10C0040);
		cmd(25'h10C0020);
		bus(1'h0, REG_SER, 32'h0);
		cmp(q, 32'h010C0020, "latest command");
		bus(1'h1, REG_NET, 32'h00000101);
		repeat (2) @(posedge clk_i);
		cmp(32'(host_conn_o), 32'h3, "two hosts");
		cmd(25'h10C0030);
		bus(1'h0, REG_SER, 32'h0);
		cmp(q, 32'h010C0020, "stored settings");
		bus(1'h0, REG_STAT, 32'h0);
		cmp(32'(q[19]), 32'h1, "command dropped");
		$display("test commands done");
		n = 0;
		while (host_conn_o !== 4'h0 && n < 17000) begin
			repeat (4) @(posedge clk_i);
			n++;
		end
		cmp(32'(n > 14000), 32'h1, "idle too early");
		repeat (8) @(posedge clk_i);
		cmp(32'(host_conn_o), 32'h0, "idle close");
		cmp(32'(n_close), 32'h1, "close pulse");
		host_req_i <= 4'h0;
		repeat (2) @(posedge clk_i);
		host_req_i <= 4'h1;
		repeat (4) @(posedge clk_i);
		cmp(32'(host_conn_o), 32'h1, "listening again");
		$display("test idle close done");
		stop_test();
	end
endmodule
